/* File: osfl_core.sv */
// Fault detection and status reporting core of the octal low-side switch
//
// How it works
// [R1] Host writes low bit to turn on
// [R2] Status shifted out reflects previous command
// [R3] Host XORs status with previous command
// [R4] Host spaces transfers over 100 us apart
// [R5] Host may repeat first word quickly
// [R6] Four fault kinds; over-voltage global
// [R7] Over-temperature turns off only that output
// [R8] Restart after over-temperature needs new write
// [R9] Over-voltage turns all off until write
// [R10] First status after over-voltage is all ones
// [R11] Open load flagged only for off outputs
// [R12] Open-load result ignored until filter expires
// [R13] Open-load indication does not latch
// [R14] One comparator: open when off, short when on
// [R15] Thermal latch-off affects faulted output only
// [R16] No fault: off reads high, on low
// [R17] Command applied on chip-select rise only
// [R18] Short shutdown holds until next write
// [R19] Sense inputs synchronised; timer counts local clock
`timescale 1ns/1ns
`default_nettype none

module osfl_core
   import osfl_pkg::*;
#(
   parameter int OL_CYC = `OSFL_OL_FILTER_CYC,
   parameter int SC_CYC = `OSFL_SC_DELAY_CYC
)
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   // Serial link
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic       si,
   output var  logic       so,
   output var  logic       so_oe,
   // Analog sense comparators and the short-shutdown mode select
   input  wire osfl_word_t drain_threshold_level,
   input  wire osfl_word_t over_temp,
   input  wire logic       load_supply_rail_ov,
   input  wire logic       short_shutdown_select,
   // Power switch gates, high turns an output on
   output var  osfl_word_t gate_on
);

   // Saturating increment for the filter timer
   function automatic logic [`OSFL_TMR_W-1:0] sat_inc(input logic [`OSFL_TMR_W-1:0] v);
      sat_inc = (v == `OSFL_TMR_MAX) ? v : v + 12'h001;
   endfunction

   // Width-safe reach test against an integer cycle count
   function automatic logic reached(input logic [`OSFL_TMR_W-1:0] v, input int cyc);
      reached = (v >= cyc[`OSFL_TMR_W-1:0]);
   endfunction

   // Synchronisers
   osfl_sense_t            sense_raw;
   osfl_sense_t            sense_meta;
   osfl_sense_t            sense;
   osfl_word_t             cmd_link;
   osfl_word_t             cmd_meta;
   osfl_word_t             cmd_sync;
   logic                   cs_prev;

   // Block state
   osfl_word_t             cmd;
   osfl_fault_t            fault;
   osfl_fault_t            next_fault;
   osfl_word_t             next_gate;
   osfl_word_t             status_hold;
   logic [`OSFL_TMR_W-1:0] tmr;
   osfl_tmr_state_t        tmr_state;
   osfl_tmr_state_t        next_tmr_state;

   // Decoded terms
   wire logic       cs_rise;
   wire logic       cs_low;
   wire osfl_word_t want_on;
   wire osfl_word_t next_cmd;
   wire logic       ol_ready;
   wire logic       sc_ready;
   wire osfl_word_t short_hit;
   wire osfl_word_t short_report;
   wire osfl_word_t open_load;
   wire osfl_word_t status_live;

   assign sense_raw.cs_n        = cs_n;
   assign sense_raw.over_volt   = load_supply_rail_ov;
   assign sense_raw.sfp_select  = short_shutdown_select;
   assign sense_raw.over_temp   = over_temp;
   assign sense_raw.drain_above = drain_threshold_level;

   // Two-stage synchronisers for pins and the link-domain command word
   always_ff @(posedge clk) begin
      sense_meta <= sense_raw; // [R19]
      sense      <= sense_meta;
      cmd_meta   <= cmd_link;
      cmd_sync   <= cmd_meta;
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cs_prev <= 1'b1;
      end else begin
         cs_prev <= sense.cs_n;
      end
   end

   assign cs_rise  = sense.cs_n & ~cs_prev;
   assign cs_low   = ~sense.cs_n | ~cs_prev;

   // Link clock is stopped by the time the rise is seen, so the word is settled
   assign next_cmd = cs_rise ? cmd_sync : cmd; // [R17]
   assign want_on  = ~cmd; // [R1]

   always_ff @(posedge clk) begin
      if (!resetn) begin
         cmd <= `OSFL_CMD_RESET;
      end else begin
         cmd <= next_cmd;
      end
   end

   // Filter timer, restarted by every chip-select rise
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tmr       <= `OSFL_TMR_ZERO;
         tmr_state <= OSFL_TMR_SETTLE;
      end else if (cs_rise) begin
         tmr       <= `OSFL_TMR_ZERO; // [R12]
         tmr_state <= OSFL_TMR_SETTLE;
      end else begin
         tmr       <= sat_inc(tmr); // [R19]
         tmr_state <= next_tmr_state;
      end
   end

   always_comb begin
      next_tmr_state = tmr_state;
      case (tmr_state)
         OSFL_TMR_SETTLE: begin
            if (reached(tmr, OL_CYC)) begin
               next_tmr_state = OSFL_TMR_OPEN;
            end
         end
         OSFL_TMR_OPEN: begin
            if (reached(tmr, SC_CYC)) begin
               next_tmr_state = OSFL_TMR_SHORT;
            end
         end
         OSFL_TMR_SHORT: begin
            next_tmr_state = OSFL_TMR_SHORT;
         end
         default: begin
            next_tmr_state = OSFL_TMR_SETTLE;
         end
      endcase
   end

   assign ol_ready = (tmr_state != OSFL_TMR_SETTLE); // [R12]
   assign sc_ready = (tmr_state == OSFL_TMR_SHORT);

   // Same comparator: above threshold while on means short
   assign short_hit    = want_on & gate_on & sense.drain_above
                         & {8{sc_ready & ~sense.sfp_select}}; // [R14] [R18]
   assign short_report = want_on & sense.drain_above & {8{sc_ready}}; // [R14]
   // Below threshold while off means open load; not latched
   assign open_load    = ~want_on & ~sense.drain_above & {8{ol_ready}}; // [R11] [R13]

   // Fault latches: a new fault wins over the clearing write
   always_comb begin
      next_fault.over_volt = sense.over_volt
                             | (fault.over_volt & ~cs_rise); // [R9] [R6]
      next_fault.over_temp = sense.over_temp
                             | (fault.over_temp & ~{8{cs_rise}}); // [R8]
      next_fault.short_off = short_hit
                             | (fault.short_off & ~{8{cs_rise}}); // [R18]
   end

   // Per-output kill leaves the other outputs alone
   assign next_gate = ~next_cmd & ~next_fault.over_temp & ~next_fault.short_off
                      & ~{8{next_fault.over_volt}}; // [R7] [R15] [R9]

   always_ff @(posedge clk) begin
      if (!resetn) begin
         fault.over_volt <= 1'b0;
         fault.over_temp <= `OSFL_NONE;
         fault.short_off <= `OSFL_NONE;
         gate_on         <= `OSFL_NONE;
      end else begin
         fault   <= next_fault;
         gate_on <= next_gate;
      end
   end

   // Status per output: high when off or faulted, low when on or when an off output sees open load
   assign status_live = fault.over_volt ? `OSFL_ALL_OFF
                        : ((~gate_on | short_report) & ~open_load); // [R16] [R10] [R6]

   // Snapshot frozen for the whole frame, so the word shifted out
   // belongs to the command written one frame earlier
   always_ff @(posedge clk) begin
      if (!resetn) begin
         status_hold <= `OSFL_STATUS_RESET;
      end else if (!cs_low) begin
         status_hold <= status_live; // [R2]
      end
   end

   osfl_serial u_serial (
      .sclk        (sclk),
      .cs_n        (cs_n),
      .si          (si),
      .so          (so),
      .so_oe       (so_oe),
      .status_word (status_hold),
      .cmd_word    (cmd_link)
   );

   // Assertions
   a_ov_all_off: assert property (@(posedge clk) disable iff (!resetn) // [R9]
      fault.over_volt |-> (gate_on == `OSFL_NONE))
      else $error("output on during over-voltage");

   a_ov_status_ff: assert property (@(posedge clk) disable iff (!resetn) // [R10]
      (fault.over_volt && !cs_low) |=> (status_hold == `OSFL_ALL_OFF))
      else $error("status not all ones after over-voltage");

   a_ot_gate_off: assert property (@(posedge clk) disable iff (!resetn) // [R7]
      (fault.over_temp & gate_on) == `OSFL_NONE)
      else $error("output on while over-temperature latched");

   a_turn_on_write: assert property (@(posedge clk) disable iff (!resetn) // [R8]
      ((gate_on & ~$past(gate_on)) != `OSFL_NONE) |-> $past(cs_rise))
      else $error("output turned on without a write");

   a_cmd_on_rise: assert property (@(posedge clk) disable iff (!resetn) // [R17]
      !$past(cs_rise) |-> (cmd == $past(cmd)))
      else $error("command changed outside chip-select rise");

   a_ol_masked: assert property (@(posedge clk) disable iff (!resetn) // [R12]
      (cs_rise ##1 1'b1 [*5]) |-> ((status_live | want_on) == `OSFL_ALL_OFF))
      else $error("open load reported inside filter time");

   a_ol_report: assert property (@(posedge clk) disable iff (!resetn) // [R11]
      (ol_ready && !fault.over_volt)
      |-> ((status_live & ~want_on & ~sense.drain_above) == `OSFL_NONE))
      else $error("open load not reported for off output");

   a_status_on_low: assert property (@(posedge clk) disable iff (!resetn) // [R16]
      (!fault.over_volt && !sc_ready) |-> ((status_live & gate_on) == `OSFL_NONE))
      else $error("on output without fault reads high");

   a_short_latch: assert property (@(posedge clk) disable iff (!resetn) // [R18]
      (short_hit != `OSFL_NONE && !cs_rise)
      |=> ((fault.short_off & $past(short_hit)) == $past(short_hit))
          ##1 ((gate_on & $past(short_hit, 2)) == `OSFL_NONE))
      else $error("short did not latch the output off");

   a_timer_order: assert property (@(posedge clk) disable iff (!resetn) // [R12]
      $rose(sc_ready) |-> ol_ready)
      else $error("short window opened before open-load window");

   a_ol_after_filter: assert property (@(posedge clk) disable iff (!resetn) // [R12]
      (open_load != `OSFL_NONE) |-> reached(tmr, OL_CYC))
      else $error("open load seen before filter count");

   a_timer_restart: assert property (@(posedge clk) disable iff (!resetn) // [R12]
      cs_rise |=> ((tmr == `OSFL_TMR_ZERO) && (tmr_state == OSFL_TMR_SETTLE)))
      else $error("filter timer not restarted by chip-select rise");

   a_ol_release: assert property (@(posedge clk) disable iff (!resetn) // [R13]
      (~want_on & sense.drain_above & ~status_live) == `OSFL_NONE)
      else $error("off output with drain above reads faulted");

   a_ot_status_off: assert property (@(posedge clk) disable iff (!resetn) // [R7]
      (fault.over_temp & want_on & ~status_live) == `OSFL_NONE)
      else $error("over-temperature output reads on");

   a_off_stays_off: assert property (@(posedge clk) disable iff (!resetn) // [R1]
      (gate_on & cmd) == `OSFL_NONE)
      else $error("output on while commanded off");

   // Current-limit mode keeps the output running, so nothing new may latch
   a_limit_no_latch: assert property (@(posedge clk) disable iff (!resetn) // [R18]
      sense.sfp_select |=> ((fault.short_off & ~$past(fault.short_off)) == `OSFL_NONE))
      else $error("short latched in current-limit mode");

endmodule

`default_nettype wire

/* File: osfl_consts.svh */
// Constants for the octal switch fault logic
`ifndef OSFL_CONSTS_SVH
`define OSFL_CONSTS_SVH

// Word layout
`define OSFL_WIDTH        8
`define OSFL_MSB          7

// Reset values
`define OSFL_CMD_RESET    8'hFF
`define OSFL_STATUS_RESET 8'hFF
`define OSFL_ALL_OFF      8'hFF
`define OSFL_NONE         8'h00

// Local clock rate in MHz (50 ns period)
`define OSFL_CLK_MHZ      20

// Open-load fault filter, least time in microseconds
`define OSFL_OL_FILTER_US 25
`define OSFL_OL_FILTER_CYC (`OSFL_OL_FILTER_US * `OSFL_CLK_MHZ)

// Short-shutdown delay after a write, least time in microseconds
`define OSFL_SC_DELAY_US  70
`define OSFL_SC_DELAY_CYC (`OSFL_SC_DELAY_US * `OSFL_CLK_MHZ)

// Filter timer width; holds the longer of the two counts
`define OSFL_TMR_W        12
`define OSFL_TMR_ZERO     12'h000
`define OSFL_TMR_MAX      12'hFFF

`endif

/* File: osfl_pkg.sv */
// Types shared by the octal switch fault logic
`include "osfl_consts.svh"

package osfl_pkg;

   typedef logic [`OSFL_MSB:0] osfl_word_t;

   // Raw and synchronised sense inputs, carried together
   typedef struct packed {
      logic       cs_n;
      logic       over_volt;
      logic       sfp_select;
      osfl_word_t over_temp;
      osfl_word_t drain_above;
   } osfl_sense_t;

   // Latched fault state per output plus the global one
   typedef struct packed {
      logic       over_volt;
      osfl_word_t over_temp;
      osfl_word_t short_off;
   } osfl_fault_t;

   // Filter timer phase after a chip-select rise
   typedef enum logic [2:0] {
      OSFL_TMR_SETTLE = 3'b001,
      OSFL_TMR_OPEN   = 3'b010,
      OSFL_TMR_SHORT  = 3'b100
   } osfl_tmr_state_t;

endpackage

/* File: osfl_serial.sv */
// Serial shift path on the link clock: command in, status out
`timescale 1ns/1ns
`default_nettype none

module osfl_serial
   import osfl_pkg::*;
(
   // Link pins
   input  wire logic       sclk,
   input  wire logic       cs_n,
   input  wire logic       si,
   output var  logic       so,
   output var  logic       so_oe,
   // Core side
   input  wire osfl_word_t status_word,
   output var  osfl_word_t cmd_word
);

   logic                   first_edge;
   logic [`OSFL_MSB-1:0]   out_shift;

   // Command bits enter MSB first, sampled on the rising edge
   always_ff @(posedge sclk) begin
      cmd_word <= {cmd_word[`OSFL_MSB-1:0], si};
   end

   // Status launched on falling edges; the frame's own select ends it,
   // since the link clock stops between frames
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         first_edge <= 1'b1;
         so_oe      <= 1'b0;
         so         <= 1'b1;
         out_shift  <= 7'h7F;
      end else if (first_edge) begin
         first_edge <= 1'b0;
         so_oe      <= 1'b1;
         so         <= status_word[`OSFL_MSB];
         out_shift  <= status_word[`OSFL_MSB-1:0];
      end else begin
         so         <= out_shift[`OSFL_MSB-1];
         out_shift  <= {out_shift[`OSFL_MSB-2:0], 1'b1};
      end
   end

endmodule

`default_nettype wire

/* File: osfl_host.sv */
// Serial host model that drives the link of the switch
`timescale 1ns/1ns
`default_nettype none

module osfl_host
   import osfl_pkg::*;
(
   // Link pins
   output var  logic sclk,
   output var  logic cs_n,
   output var  logic si,
   input  wire logic so
);
   initial begin
      sclk = 1'b1;
      cs_n = 1'b1;
      si   = 1'b0;
   end

   // One frame of 48 ns link clock; the clock stands still outside frames
   task automatic xfer(input osfl_word_t cmd, output osfl_word_t st);
      cs_n = 1'b0;
      #250; // Status snapshot must freeze first
      for (int i = 7; i >= 0; i--) begin
         sclk = 1'b0;
         si   = cmd[i];
         #24;
         sclk  = 1'b1;
         st[i] = so;
         #24;
      end
      cs_n = 1'b1;
      // Released line shows the inverse, not a stale bit
      si   = ~si;
   endtask
endmodule

`default_nettype wire

/* File: osfl_core_tb.sv */
// Self-checking bench for the octal switch fault core
`timescale 1ns/1ns
`default_nettype none

module osfl_core_tb
   import osfl_pkg::*;
;
   logic       clk;
   logic       resetn;
   wire        sclk;
   wire        cs_n;
   wire        si;
   wire        so;
   wire        so_oe;
   osfl_word_t drain;
   osfl_word_t ot;
   logic       ov;
   logic       sfp;
   osfl_word_t gate_on;
   osfl_word_t st;
   int         mismatches;
   int         n_checks;

   osfl_core #(.OL_CYC(5), .SC_CYC(12)) dut (
      .clk(clk), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .si(si),
      .so(so), .so_oe(so_oe), .drain_threshold_level(drain),
      .over_temp(ot), .load_supply_rail_ov(ov),
      .short_shutdown_select(sfp), .gate_on(gate_on));

   osfl_host host (.sclk(sclk), .cs_n(cs_n), .si(si), .so(so));

   initial clk = 1'b0;
   always #25 clk = ~clk;

   task automatic chk(input string nm, input osfl_word_t seen, input osfl_word_t exp);
      n_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic gap(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Off reads high, on reads low; status lags one frame
   task automatic t_basic();
      drain = 8'hA5;
      host.xfer(8'hA5, st);
      chk("first status", st, 8'hFF);
      chk("gates held", gate_on, 8'h00);
      gap(8);
      chk("so_oe idle", {7'h00, so_oe}, 8'h00);
      chk("gates", gate_on, 8'h5A);
      gap(40);
      host.xfer(8'hA5, st);
      chk("status xor", st ^ 8'hA5, 8'h00);
      chk("status", st, 8'hA5);
      // Select must be seen high before the next frame
      gap(8);
   endtask

   // Over-temperature drops one output; restart needs a write
   task automatic t_temp();
      drain = 8'h00;
      host.xfer(8'h00, st);
      gap(40);
      ot = 8'h08;
      gap(8);
      chk("ot gates", gate_on, 8'hF7);
      ot = 8'h00;
      gap(8);
      chk("ot held", gate_on, 8'hF7);
      host.xfer(8'h00, st);
      chk("ot status", st, 8'h08);
      gap(8);
      chk("ot rewrite", gate_on, 8'hFF);
      gap(40);
   endtask

   // Over-voltage shuts all until removed and rewritten; open loads
   // on the off half would read low if the all-ones word were missing
   task automatic t_ov();
      host.xfer(8'h0F, st);
      gap(40);
      ov = 1'b1;
      gap(8);
      chk("ov gates", gate_on, 8'h00);
      ov = 1'b0;
      gap(8);
      chk("ov held", gate_on, 8'h00);
      host.xfer(8'h00, st);
      chk("ov status", st, 8'hFF);
      gap(8);
      chk("ov rewrite", gate_on, 8'hFF);
      gap(40);
   endtask

   // Short in current-limit mode, then latched with shutdown select low
   task automatic t_short();
      drain = 8'h20;
      gap(40);
      chk("cl gates", gate_on, 8'hFF);
      sfp = 1'b0;
      gap(40);
      chk("sc gates", gate_on, 8'hDF);
      drain = 8'h00;
      gap(20);
      chk("sc held", gate_on, 8'hDF);
      host.xfer(8'h00, st);
      chk("sc status", st, 8'h20);
      gap(8);
      chk("sc rewrite", gate_on, 8'hFF);
      gap(40);
   endtask

   // Open load on an off output, filtered and not latched
   task automatic t_open();
      host.xfer(8'hFF, st);
      gap(1);
      drain = 8'hFB;
      gap(4);
      host.xfer(8'hFF, st);
      chk("ol filtered", st, 8'hFF);
      gap(40);
      host.xfer(8'hFF, st);
      chk("ol flag", st, 8'hFB);
      gap(1);
      drain = 8'hFF;
      gap(39);
      host.xfer(8'hFF, st);
      chk("ol clear", st, 8'hFF);
   endtask

   initial begin
      mismatches = 0;
      n_checks = 0;
      resetn = 1'b0;
      drain = 8'hFF;
      ot = 8'h00;
      ov = 1'b0;
      sfp = 1'b1;
      gap(12);
      resetn = 1'b1;
      gap(4);
      t_basic();
      t_temp();
      t_ov();
      t_short();
      t_open();
      end_sim();
   end

   // Tests need well under 2000 cycles
   initial begin
      #2000000;
      mismatches++;
      end_sim();
   end
endmodule

`default_nettype wire
